// ### hw/vdo_pkg.sv
/*
  Constants, register map and carrier types for the video output timing port.
  Assumes a single 200 MHz clock; all slower output rates are enables from a divider.
*/
// Summary of operation
// - Line sync pulse lasts 64 output clock cycles; its rise starts a line.
// - A timing control bit makes line sync width count pixels instead of clocks.
// - Field sync changes on 1x clock rise, lasts six lines, rise starts a field.
// - Each timing output polarity follows its bit in the sync polarity register.
// - Active output shows composite or horizontal-only active, chosen by timing control.
// - Active output is high over the programmed viewable region by default.
// - Qualified pixel clock rises only for valid pixels, optionally gated by active.
// - Qualified pixel clock is inverted against its source output clock.
// - In control-code mode, qualified pixel clock is held quiet during codes.
// - Video, timing and clock outputs drive from the 2x clock rise after low output enable, else float.
// - Output group select bits disable data, timing or clock pin groups.
// - Field output is high for odd fields and low for even fields.
// - Blue chroma flag is high for Cb bytes and low for Cr bytes.
// - Sixteen-bit mode uses the whole bus on 1x; eight-bit uses upper byte on 2x.
// - In control-code mode, control codes are inserted among the pixel data.
// - In eight-bit mode the low data byte serves as general purpose pins.
// - Pixel valid is asserted only on output clocks carrying a valid pixel.
// - Caption flag is pulled low while the caption FIFO holds at least eight characters.
// - A control bit disables the caption flag so it stays inactive.
// - With the default config pin high at reset, video, sync, clocks float.

package vdo_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_TIMING_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SYNC_POL = 8'h04;
  localparam logic [7:0] ADDR_OUT_FMT = 8'h08;
  localparam logic [7:0] ADDR_LINE_LEN = 8'h0c;
  localparam logic [7:0] ADDR_HACTIVE = 8'h10;
  localparam logic [7:0] ADDR_VACTIVE = 8'h14;
  localparam logic [7:0] ADDR_FIELD_LINES = 8'h18;
  localparam logic [7:0] ADDR_GPIO = 8'h1c;
  localparam logic [7:0] ADDR_CAPTION = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // Field positions
  localparam int TC_HS_FMT = 0;
  localparam int TC_ACT_HONLY = 1;
  localparam int TC_QUALIFIED_PIXEL_CLOCK_GATE = 2;
  localparam int POL_LINE = 0;
  localparam int POL_FIELD_SYNC = 1;
  localparam int POL_ACTIVE = 2;
  localparam int POL_FIELD = 3;
  localparam int POL_CB = 4;
  localparam int POL_VALID = 5;
  localparam int OF_MODE8 = 0;
  localparam int OF_CODES = 1;
  localparam int OF_OES_DATA = 2;
  localparam int OF_OES_TIMING = 3;
  localparam int OF_OES_CLOCK = 4;
  localparam int OF_RELEASE = 5;

  // Reset values
  localparam logic [2:0] TIMING_CTRL_RST = 3'h0;
  localparam logic [5:0] SYNC_POL_RST = 6'h00;
  localparam logic [4:0] OUT_FMT_RST = 5'h00;
  localparam logic [11:0] LINE_LEN_RST = 12'h320;
  localparam logic [11:0] HSTART_RST = 12'h080;
  localparam logic [11:0] HSTOP_RST = 12'h300;
  localparam logic [9:0] VSTART_RST = 10'h014;
  localparam logic [9:0] VSTOP_RST = 10'h100;
  localparam logic [9:0] FIELD_LINES_RST = 10'h106;

  // Timing counts
  localparam logic [1:0] CLK2X_HALF_CYC = 2'h2;
  localparam logic [1:0] DIV_LAST = CLK2X_HALF_CYC - 2'h1;
  localparam int CYC_PER_1X = 4 * int'(CLK2X_HALF_CYC);
  localparam logic [6:0] LINE_SYNC_WIDTH = 7'h40;
  localparam int LINE_SYNC_CYC = int'(LINE_SYNC_WIDTH) * CYC_PER_1X;
  localparam logic [9:0] FIELD_SYNC_LINES = 10'h006;
  localparam logic [4:0] CAPTION_HALF_LEVEL = 5'h08;
  localparam logic [7:0] CODE_PREFIX = 8'hff;

  // What the data bus carries
  typedef enum logic [1:0] {BUS_IDLE, BUS_CODE, BUS_PIXEL} vdo_bus_e;

  // Pixel from the scaler
  typedef struct packed {
    logic valid;
    logic [7:0] y;
    logic [7:0] c;
    logic is_cb;
  } vdo_pix_s;

  // Timing and clock pins
  typedef struct packed {
    logic line_sync;
    logic field_sync;
    logic active;
    logic field;
    logic blue_chroma;
    logic pixel_valid;
    logic qualified_pixel_clock;
    logic clk1x;
    logic clk2x;
  } vdo_pins_s;

endpackage : vdo_pkg

// ### hw/vdo_timing_port.sv
/*
  Output timing port of a video decoder: syncs, active, field, chroma flag,
  pixel valid, qualified clock, pixel bus with control codes, GPIO and caption flag.
  Assumes an AHB-Lite master, a scaler delivering pixels on the same clock, and
  external pins resolved from the output enables by the surrounding pad logic.
*/
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module vdo_timing_port
  import vdo_pkg::*;
(
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire vdo_pix_s PIX_IN,
  output logic PIX_TAKE,
  input wire logic [4:0] CC_LEVEL,
  input wire logic OE_N_PIN,
  input wire logic DEFAULT_CONFIG_PIN,
  input wire logic [7:0] VD_IN,
  output logic [15:0] VD_OUT,
  output logic [15:0] VD_OE,
  output vdo_pins_s TIMING_OUT,
  output logic TIMING_OE,
  output logic CLOCK_OE,
  output logic CAPTION_OUT,
  output logic CAPTION_OE
);

  // ********************************
  // Declarations
  // ********************************
  logic [2:0] tc_q;
  logic [5:0] pol_q;
  logic [4:0] of_q;
  logic [11:0] line_len_q, hstart_q, hstop_q, h_q;
  logic [9:0] vstart_q, vstop_q, field_lines_q, v_q;
  logic [7:0] gpio_out_q, gpio_oe_q, gpio_in_q;
  logic cc_dis_q;
  logic wr_pend_q;
  logic [7:0] addr_q;
  logic [31:0] hrdata_q, rd_data;
  logic [1:0] div_q;
  logic clk2x_q, clk1x_q, rise2x, rise1x, rise2x_hi;
  logic oe_s1, oe_s2, oe_s3, oe_low_q;
  logic st_s1, st_s2, st_s3, strap_level_q, strap_tri_q;
  logic [7:0] gp_s1, gp_s2, gp_s3;
  logic out_en_q;
  logic line_wrap, field_wrap, h_act, v_act, act_raw, field_odd_q;
  logic hs_q, hs_step, vs_q, act_q;
  logic [6:0] hs_cnt_q;
  vdo_bus_e bus_q;
  vdo_pix_s pix_q;
  logic [15:0] vd_q;
  logic valid_q, cb_q, qual_q, qualified_pixel_clock_raw;
  logic [7:0] code_stat;
  logic mode8, codes_en;

  assign mode8 = of_q[OF_MODE8];
  assign codes_en = of_q[OF_CODES];

  // ********************************
  // AHB-Lite register slave
  // ********************************
  // Zero wait state, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = hrdata_q;

  // Read decode from the address phase
  always_comb
  begin
    rd_data = 32'h0;
    unique case (HADDR[7:0])
      ADDR_TIMING_CTRL: rd_data = {29'h0, tc_q};
      ADDR_SYNC_POL: rd_data = {26'h0, pol_q};
      ADDR_OUT_FMT: rd_data = {26'h0, strap_tri_q, of_q};
      ADDR_LINE_LEN: rd_data = {20'h0, line_len_q};
      ADDR_HACTIVE: rd_data = {4'h0, hstop_q, 4'h0, hstart_q};
      ADDR_VACTIVE: rd_data = {6'h0, vstop_q, 6'h0, vstart_q};
      ADDR_FIELD_LINES: rd_data = {22'h0, field_lines_q};
      ADDR_GPIO: rd_data = {8'h0, gpio_in_q, gpio_oe_q, gpio_out_q};
      ADDR_CAPTION: rd_data = {31'h0, cc_dis_q};
      ADDR_STATUS: rd_data = {13'h0, strap_tri_q, out_en_q, field_odd_q, 6'h0, v_q};
      default: rd_data = 32'h0;
    endcase
  end

  // Address phase capture and read data
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h0;
      hrdata_q <= 32'h0;
    end
    else if (HREADY)
    begin
      wr_pend_q <= HSEL && HTRANS[1] && HWRITE && (HSIZE == 3'h2);
      addr_q <= HADDR[7:0];
      if (HSEL && HTRANS[1] && !HWRITE)
        hrdata_q <= rd_data;
    end
  end

  // Register writes in the data phase
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      tc_q <= TIMING_CTRL_RST;
      pol_q <= SYNC_POL_RST;
      of_q <= OUT_FMT_RST;
      line_len_q <= LINE_LEN_RST;
      hstart_q <= HSTART_RST;
      hstop_q <= HSTOP_RST;
      vstart_q <= VSTART_RST;
      vstop_q <= VSTOP_RST;
      field_lines_q <= FIELD_LINES_RST;
      gpio_out_q <= 8'h0;
      gpio_oe_q <= 8'h0;
      cc_dis_q <= 1'b0;
    end
    else if (wr_pend_q)
    begin
      unique case (addr_q)
        ADDR_TIMING_CTRL: tc_q <= HWDATA[2:0];
        ADDR_SYNC_POL: pol_q <= HWDATA[5:0];
        ADDR_OUT_FMT: of_q <= HWDATA[4:0];
        ADDR_LINE_LEN: line_len_q <= HWDATA[11:0];
        ADDR_HACTIVE:
        begin
          hstart_q <= HWDATA[11:0];
          hstop_q <= HWDATA[27:16];
        end
        ADDR_VACTIVE:
        begin
          vstart_q <= HWDATA[9:0];
          vstop_q <= HWDATA[25:16];
        end
        ADDR_FIELD_LINES: field_lines_q <= HWDATA[9:0];
        ADDR_GPIO:
        begin
          gpio_out_q <= HWDATA[7:0];
          gpio_oe_q <= HWDATA[15:8];
        end
        ADDR_CAPTION: cc_dis_q <= HWDATA[0];
        default: ;
      endcase
    end
  end

  // ********************************
  // Pin synchronisers and straps
  // ********************************
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge CLOCK)
  begin
    oe_s1 <= OE_N_PIN;
    oe_s2 <= oe_s1;
    oe_s3 <= oe_s2;
    st_s1 <= DEFAULT_CONFIG_PIN;
    st_s2 <= st_s1;
    st_s3 <= st_s2;
    gp_s1 <= VD_IN;
    gp_s2 <= gp_s1;
    gp_s3 <= gp_s2;
    if (oe_s2 == oe_s3)
      oe_low_q <= !oe_s3;
    if (st_s2 == st_s3)
      strap_level_q <= st_s3;
    gpio_in_q <= (gp_s2 & gp_s3) | (gpio_in_q & (gp_s2 ^ gp_s3));
  end

  // Strap caught while reset is held; software release clears it
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      strap_tri_q <= strap_level_q;
    else if (wr_pend_q && addr_q == ADDR_OUT_FMT && HWDATA[OF_RELEASE])
      strap_tri_q <= 1'b0;
  end

  // Drive starts on a 2x rise after enable; release is immediate
  always_ff @(posedge CLOCK)
  begin
    if (RST || !oe_low_q || strap_tri_q)
      out_en_q <= 1'b0;
    else if (rise2x)
      out_en_q <= 1'b1;
  end

  // ********************************
  // Output clock divider
  // ********************************
  assign rise2x = (div_q == DIV_LAST) && !clk2x_q;
  assign rise1x = rise2x && !clk1x_q;
  assign rise2x_hi = rise2x && clk1x_q;
  assign PIX_TAKE = rise1x;

  // 2x and 1x clock levels
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      div_q <= 2'h0;
      clk2x_q <= 1'b0;
      clk1x_q <= 1'b0;
    end
    else if (div_q == DIV_LAST)
    begin
      div_q <= 2'h0;
      clk2x_q <= !clk2x_q;
      if (rise2x)
        clk1x_q <= !clk1x_q;
    end
    else
      div_q <= div_q + 2'h1;
  end

  // ********************************
  // Raster counters and timing signals
  // ********************************
  assign line_wrap = (h_q == line_len_q - 12'h1);
  assign field_wrap = line_wrap && (v_q == field_lines_q - 10'h1);
  assign h_act = (h_q >= hstart_q) && (h_q < hstop_q);
  assign v_act = (v_q >= vstart_q) && (v_q < vstop_q);
  assign act_raw = tc_q[TC_ACT_HONLY] ? h_act : (h_act && v_act);
  assign code_stat = {1'b1, field_odd_q, !v_act, h_q == hstop_q, 4'h0};

  // Horizontal, vertical and field state on the 1x rise
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      h_q <= 12'h0;
      v_q <= 10'h0;
      field_odd_q <= 1'b1;
      vs_q <= 1'b0;
      act_q <= 1'b0;
    end
    else if (rise1x)
    begin
      h_q <= line_wrap ? 12'h0 : h_q + 12'h1;
      if (field_wrap)
      begin
        v_q <= 10'h0;
        field_odd_q <= !field_odd_q;
      end
      else if (line_wrap)
        v_q <= v_q + 10'h1;
      vs_q <= (v_q < FIELD_SYNC_LINES);
      act_q <= act_raw;
    end
  end

  // Line sync: counts 1x clocks or valid pixels
  assign hs_step = tc_q[TC_HS_FMT] ? (rise1x && PIX_IN.valid) : rise1x;

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      hs_q <= 1'b0;
      hs_cnt_q <= 7'h0;
    end
    else if (rise1x && line_wrap)
    begin
      hs_q <= 1'b1;
      hs_cnt_q <= 7'h1;
    end
    else if (hs_q && hs_step)
    begin
      if (hs_cnt_q == LINE_SYNC_WIDTH)
        hs_q <= 1'b0;
      else
        hs_cnt_q <= hs_cnt_q + 7'h1;
    end
  end

  // ********************************
  // Pixel bus, codes and qualifiers
  // ********************************
  // Word or first byte on the 1x rise, second byte on the next 2x rise
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      bus_q <= BUS_IDLE;
      pix_q <= '0;
      vd_q <= 16'h0;
      valid_q <= 1'b0;
      cb_q <= 1'b0;
      qual_q <= 1'b0;
    end
    else if (rise1x)
    begin
      pix_q <= PIX_IN;
      if (codes_en && (h_q == hstart_q || h_q == hstop_q))
      begin
        bus_q <= BUS_CODE;
        vd_q <= {CODE_PREFIX, code_stat}; // Status held for the second byte
        valid_q <= 1'b0;
        qual_q <= 1'b0;
      end
      else
      begin
        bus_q <= PIX_IN.valid ? BUS_PIXEL : BUS_IDLE;
        vd_q <= mode8 ? {PIX_IN.c, 8'h0} : {PIX_IN.y, PIX_IN.c};
        valid_q <= PIX_IN.valid;
        qual_q <= PIX_IN.valid && (!tc_q[TC_QUALIFIED_PIXEL_CLOCK_GATE] || act_raw);
      end
      cb_q <= PIX_IN.is_cb;
    end
    else if (rise2x_hi && mode8)
    begin
      unique case (bus_q)
        BUS_CODE: vd_q[15:8] <= vd_q[7:0];
        BUS_PIXEL: vd_q[15:8] <= pix_q.y;
        BUS_IDLE: vd_q[15:8] <= 8'h0;
      endcase
    end
  end

  // Inverted source clock, gated by the qualifier
  assign qualified_pixel_clock_raw = qual_q && !(mode8 ? clk2x_q : clk1x_q);

  // ********************************
  // Pin drive
  // ********************************
  // Polarity applied per timing output
  always_comb
  begin
    TIMING_OUT.line_sync = hs_q ^ pol_q[POL_LINE];
    TIMING_OUT.field_sync = vs_q ^ pol_q[POL_FIELD_SYNC];
    TIMING_OUT.active = act_q ^ pol_q[POL_ACTIVE];
    TIMING_OUT.field = field_odd_q ^ pol_q[POL_FIELD];
    TIMING_OUT.blue_chroma = cb_q ^ pol_q[POL_CB];
    TIMING_OUT.pixel_valid = valid_q ^ pol_q[POL_VALID];
    TIMING_OUT.qualified_pixel_clock = qualified_pixel_clock_raw;
    TIMING_OUT.clk1x = clk1x_q;
    TIMING_OUT.clk2x = clk2x_q;
  end

  // Group enables; low byte becomes GPIO in eight-bit mode
  assign TIMING_OE = out_en_q && !of_q[OF_OES_TIMING];
  assign CLOCK_OE = out_en_q && !of_q[OF_OES_CLOCK];
  assign VD_OE[15:8] = {8{out_en_q && !of_q[OF_OES_DATA]}};
  assign VD_OE[7:0] = mode8 ? gpio_oe_q : {8{out_en_q && !of_q[OF_OES_DATA]}};
  assign VD_OUT = {vd_q[15:8], mode8 ? gpio_out_q : vd_q[7:0]};

  // Open-drain caption flag
  assign CAPTION_OUT = 1'b0;
  assign CAPTION_OE = (CC_LEVEL >= CAPTION_HALF_LEVEL) && !cc_dis_q;

  // ********************************
  // Assertions
  // ********************************
  logic [9:0] hs_cyc_q;

  // Cycles spent in the line sync pulse
  always_ff @(posedge CLOCK)
  begin
    if (RST || !hs_q)
      hs_cyc_q <= 10'h0;
    else
      hs_cyc_q <= hs_cyc_q + 10'h1;
  end

  default clocking cb_main @(posedge CLOCK); endclocking
  default disable iff (RST);

  sequence oe_go_s;
    oe_low_q && !strap_tri_q && rise2x;
  endsequence

  sequence oe_off_s;
    !oe_low_q || strap_tri_q;
  endsequence

  line_sync_width_a: assert property ($fell(hs_q) && !tc_q[TC_HS_FMT] && !$past(rise1x && line_wrap)
    |-> $past(hs_cyc_q) == 10'(LINE_SYNC_CYC - 1)) else $error("line sync width wrong");
  field_sync_edge_a: assert property ($changed(vs_q) |-> $past(rise1x))
    else $error("field sync moved off 1x rise");
  qualified_pixel_clock_quiet_a: assert property ($rose(qualified_pixel_clock_raw) |-> valid_q && bus_q == BUS_PIXEL)
    else $error("qualified clock rose without valid pixel");
  qualified_pixel_clock_phase_a: assert property (qualified_pixel_clock_raw |-> !(mode8 ? clk2x_q : clk1x_q))
    else $error("qualified clock not inverted");
  code_gap_a: assert property (bus_q == BUS_CODE |-> !qualified_pixel_clock_raw && !valid_q)
    else $error("qualified clock during code");
  oe_start_a: assert property (oe_go_s |=> out_en_q)
    else $error("outputs not driven after 2x rise");
  oe_stop_a: assert property (oe_off_s |=> !out_en_q && !VD_OE[15])
    else $error("outputs still driven");
  group_mask_a: assert property (of_q[OF_OES_TIMING] |-> !TIMING_OE)
    else $error("timing group not disabled");
  aligned_update_a: assert property (($changed(valid_q) || $changed(cb_q)) |-> $past(rise1x))
    else $error("pixel qualifiers off the 1x edge");
  caption_flag_a: assert property (cc_dis_q |-> !CAPTION_OE)
    else $error("caption flag active while disabled");
  bus_okay_a: assert property (HREADYOUT && !HRESP)
    else $error("bus response not OKAY");

endmodule : vdo_timing_port

`default_nettype wire

// ### verification/vdo_capture_model.sv
/*
  Capture controller model: samples the pixel bus on each qualified clock rise.
  Assumes it runs on the system clock, well above the pixel clock rates.
*/
`timescale 1ns/1ps
`default_nettype none

module vdo_capture_model
  import vdo_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] vd,
  input wire vdo_pins_s pins,
  input wire logic cc_oe,
  input wire logic cc_out,
  output logic cap_q,
  output logic [15:0] vd_q,
  output vdo_pins_s pins_q,
  output logic cc_wire
);
  // ***********************
  // Sampling
  // ***********************
  logic qualified_pixel_clock_q;

  // Qualified clock rise takes the bus and the flags
  always_ff @(posedge clk)
  begin
    qualified_pixel_clock_q <= pins.qualified_pixel_clock;
    cap_q <= pins.qualified_pixel_clock & ~qualified_pixel_clock_q;
    vd_q <= vd;
    pins_q <= pins;
  end

  // Open drain flag line with its pull-up
  assign cc_wire = cc_oe ? cc_out : 1'h1;

endmodule : vdo_capture_model

`default_nettype wire

// ### verification/vdo_timing_port_tb.sv
/*
  Bench for the video output timing port: bus tasks, pixel feed and tests.
  Assumes a zero-wait bus slave and the capture model beside the port.
*/
`timescale 1ns/1ps
`default_nettype none

module video_decoder_output_timing_port_tb_top
  import vdo_pkg::*;
;
  // ***********************
  // Signals
  // ***********************
  localparam int FS_CYC = int'(FIELD_SYNC_LINES) * CYC_PER_1X * 80;
  logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, oe_n = 1'h0, strap = 1'h1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hresp, take, tk, cap, cc_oe, cc_out, cc_wire, toe, coe, fld;
  logic mode8 = 1'h0, codes = 1'h0, on = 1'h1, hv = 1'h0, gate = 1'h0;
  logic [4:0] cc_lvl = 5'h0;
  logic [7:0] vd_in = 8'h3c, hb = 8'h0;
  logic [15:0] vd, vd_oe, cap_vd;
  logic [6:0] pn = 7'h0;
  vdo_pins_s pins, cap_p;
  vdo_pix_s pix;
  int err_count = 0, samples_checked = 0, ncode = 0, ncap = 0, na, n, w;
  // Status after reset: strap float, outputs off, odd field, line 0
  logic [7:0] ra [10] = '{ADDR_TIMING_CTRL, ADDR_SYNC_POL, ADDR_OUT_FMT, ADDR_LINE_LEN,
    ADDR_HACTIVE, ADDR_VACTIVE, ADDR_FIELD_LINES, ADDR_CAPTION, 8'h28, ADDR_STATUS};
  logic [31:0] rv [10] = '{32'(TIMING_CTRL_RST), 32'(SYNC_POL_RST), {26'h0, 1'h1, OUT_FMT_RST},
    32'(LINE_LEN_RST), {4'h0, HSTOP_RST, 4'h0, HSTART_RST}, {6'h0, VSTOP_RST, 6'h0, VSTART_RST},
    32'(FIELD_LINES_RST), 32'h0, 32'h0, 32'h00050000};

  // Clock, and a pixel stream where every other pixel is valid
  always #2.5 clk = ~clk;
  assign pix = '{pn[0], {1'h0, pn}, ~{1'h0, pn}, pn[1]};
  always @(negedge clk) tk <= take;
  always @(posedge clk)
    if (tk)
      pn <= pn + 7'h1;

  vdo_timing_port i_vdo_timing_port (
    .CLOCK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready),
    .HRESP(hresp), .PIX_IN(pix), .PIX_TAKE(take), .CC_LEVEL(cc_lvl), .OE_N_PIN(oe_n),
    .DEFAULT_CONFIG_PIN(strap), .VD_IN(vd_in), .VD_OUT(vd), .VD_OE(vd_oe), .TIMING_OUT(pins),
    .TIMING_OE(toe), .CLOCK_OE(coe), .CAPTION_OUT(cc_out), .CAPTION_OE(cc_oe));

  vdo_capture_model i_vdo_capture_model (.clk(clk), .vd(vd), .pins(pins), .cc_oe(cc_oe),
    .cc_out(cc_out), .cap_q(cap), .vd_q(cap_vd), .pins_q(cap_p), .cc_wire(cc_wire));

  // ***********************
  // Tasks
  // ***********************
  task automatic cmp_bit(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : cmp_bit

  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %0t %s got %h", $time, m, g);
    end
  endtask : cmp_word

  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    for (w = 0; w < 50 && hready !== 1'h1; w++) @(posedge clk);
    @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= d;
    for (w = 0; w < 50 && hready !== 1'h1; w++) @(posedge clk);
    @(posedge clk);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d, r);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, r);
    cmp_word(r, e, "reg read");
  endtask : rchk

  // Waits for the enables, then checks they came on a 2x rise
  task automatic wait_oe(input logic e);
    for (w = 0; w < 40 && toe !== e; w++) @(negedge clk);
    cmp_bit(toe, e, "timing oe");
    cmp_bit(coe & vd_oe[15], e, "clock data oe");
    if (e)
      cmp_bit(pins.clk2x, 1'h1, "oe edge");
    @(posedge clk);
  endtask : wait_oe

  // Switches output format with the monitor paused
  task automatic fmt(input logic [31:0] v);
    on = 1'h0;
    hv = 1'h0;
    wr(ADDR_OUT_FMT, v);
    repeat (16) @(posedge clk);
    mode8 = v[OF_MODE8];
    codes = v[OF_CODES];
    on = 1'h1;
  endtask : fmt

  function automatic logic sel(input int s);
    return s == 0 ? pins.line_sync : s == 1 ? pins.field_sync : pins.active;
  endfunction : sel

  // Width in cycles of the next whole pulse at level l
  task automatic pulse(input int s, input logic l);
    for (w = 0; w < 9000 && sel(s) === l; w++) @(negedge clk);
    for (w = 0; w < 9000 && sel(s) !== l; w++) @(negedge clk);
    na = 0;
    for (n = 0; n < 9000 && sel(s) === l; n++)
    begin
      @(negedge clk);
      na += int'(pins.active);
    end
    fld = pins.field;
    @(posedge clk);
  endtask : pulse

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Judge every sample that the capture model takes while the monitor is on
  always @(negedge clk)
  begin
    if (codes && vd[15:8] == CODE_PREFIX)
      ncode++;
    if (cap && on)
    begin
      ncap++;
      cmp_bit(cap_p.pixel_valid, 1'h1, "qualified_pixel_clock no valid");
      cmp_bit(cap_vd[15:8] != CODE_PREFIX, 1'h1, "qualified_pixel_clock on code");
      if (gate)
        cmp_bit(cap_p.active, 1'h1, "qualified_pixel_clock outside active");
      if (!mode8)
      begin
        cmp_word(32'({cap_vd[8], cap_vd[7:0]}), 32'({1'h1, ~cap_vd[15:8]}), "pixel");
        cmp_bit(cap_p.blue_chroma, cap_vd[9], "cb");
      end
      else if (cap_p.clk1x)
      begin
        hb = cap_vd[15:8];
        hv = 1'h1;
        cmp_bit(cap_p.blue_chroma, ~cap_vd[9], "cb 8");
      end
      else if (hv)
        cmp_word(32'({cap_vd[8], cap_vd[15:8]}), 32'({1'h1, ~hb}), "pixel 8");
    end
  end

  // ***********************
  // Tests
  // ***********************
  initial
  begin
    logic f;
    f = 1'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    for (int i = 0; i < 10; i++)
      rchk(ra[i], rv[i]);
    cmp_bit(toe | coe | vd_oe[15], 1'h0, "strap float");
    wr(ADDR_OUT_FMT, 32'h20);
    wait_oe(1'h1);
    oe_n <= 1'h1;
    wait_oe(1'h0);
    oe_n <= 1'h0;
    wait_oe(1'h1);
    for (int b = 2; b < 5; b++)
    begin
      wr(ADDR_OUT_FMT, 32'h1 << b);
      repeat (3) @(negedge clk);
      cmp_word(32'({vd_oe[15], toe, coe}), 32'(3'h7 ^ (3'h4 >> (b - 2))), "group");
      @(posedge clk);
    end
    wr(ADDR_OUT_FMT, 32'h0);
    $display("enable test done");
    wr(ADDR_LINE_LEN, 32'h50);
    wr(ADDR_FIELD_LINES, 32'ha);
    wr(ADDR_HACTIVE, 32'h0040_0010);
    wr(ADDR_VACTIVE, 32'h0009_0007);
    pulse(0, 1'h1);
    cmp_word(32'(n), 32'(LINE_SYNC_CYC), "line sync");
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_TIMING_CTRL, 32'(m << TC_ACT_HONLY));
      pulse(1, 1'h1);
      cmp_word(32'(n), 32'(FS_CYC), "field sync");
      cmp_bit(na != 0, m[0], "active mode");
      if (m == 1)
        cmp_bit(fld, ~f, "field flip");
      f = fld;
    end
    pulse(2, 1'h1);
    cmp_word(32'(n), 32'(48 * CYC_PER_1X), "active width");
    wr(ADDR_SYNC_POL, 32'h3);
    pulse(0, 1'h0);
    cmp_word(32'(n), 32'(LINE_SYNC_CYC), "line pol");
    pulse(1, 1'h0);
    cmp_word(32'(n), 32'(FS_CYC), "field pol");
    wr(ADDR_SYNC_POL, 32'h0);
    $display("timing test done");
    cmp_bit(ncap > 0, 1'h1, "no qualified_pixel_clock");
    fmt(32'h1);
    wr(ADDR_GPIO, 32'hffa5);
    repeat (200) @(negedge clk);
    cmp_word(32'({vd_oe[7:0], vd[7:0]}), 32'hffa5, "gpio out");
    cmp_bit(hv, 1'h1, "no 8 bit qualified_pixel_clock");
    @(posedge clk);
    rchk(ADDR_GPIO, 32'h3cffa5);
    // Codes in both bus widths, qualified clock gated by active
    wr(ADDR_TIMING_CTRL, 32'h6);
    for (int k = 2; k < 4; k++)
    begin
      fmt(32'(k));
      gate = 1'h1;
      na = ncode;
      n = ncap;
      repeat (1400) @(posedge clk);
      cmp_bit(ncode > na, 1'h1, "no code");
      cmp_bit(ncap > n, 1'h1, "no gated qualified_pixel_clock");
    end
    gate = 1'h0;
    fmt(32'h0);
    $display("pixel test done");
    cc_lvl <= 5'h7;
    @(negedge clk);
    cmp_bit(cc_wire, 1'h1, "cc 7");
    @(posedge clk);
    cc_lvl <= 5'h8;
    @(negedge clk);
    cmp_bit(cc_wire, 1'h0, "cc 8");
    @(posedge clk);
    wr(ADDR_CAPTION, 32'h1);
    @(negedge clk);
    cmp_bit(cc_wire, 1'h1, "cc off");
    @(posedge clk);
    $display("caption test done");
    wr(ADDR_LINE_LEN, 32'ha0);
    wr(ADDR_TIMING_CTRL, 32'h1);
    pulse(0, 1'h1);
    cmp_word(32'((n + 8) / 16), 32'(LINE_SYNC_WIDTH), "pixel width");
    $display("width test done");
    end_sim();
  end

  // Watchdog
  initial
  begin
    repeat (95000) @(posedge clk);
    err_count++;
    end_sim();
  end

endmodule : video_decoder_output_timing_port_tb_top

`default_nettype wire
